// File: src/rps_defs.vh
// Offsets, field positions and reset values of the per-port receive status registers
`ifndef RPS_DEFS_VH
`define RPS_DEFS_VH

// Register offsets
`define RPS_OFS_PORT_SEL   8'h4c
`define RPS_OFS_STATUS_ONE 8'h4d
`define RPS_OFS_STATUS_TWO 8'h4e
`define RPS_OFS_FREQ_INT   8'h4f
`define RPS_OFS_FREQ_FRAC  8'h50
`define RPS_OFS_FAULT_DET  8'h5a

// Port select fields
`define RPS_SEL_READ_HI    5
`define RPS_SEL_READ_LO    4
`define RPS_PORT_SEL_RST   8'h00

// Status one fields
`define RPS_S1_PORT_HI     7
`define RPS_S1_PORT_LO     6
`define RPS_S1_CRC         5
`define RPS_S1_LOCK_CHG    4
`define RPS_S1_CTRL        3
`define RPS_S1_PARITY      2
`define RPS_S1_PASS        1
`define RPS_S1_LOCKED      0

// Status two fields
`define RPS_S2_LEN_UNSTEADY 7
`define RPS_S2_LEN_CHG      6
`define RPS_S2_ENCODE       5
`define RPS_S2_BUFFER       4
`define RPS_S2_CAMERA       3
`define RPS_S2_FREQ_OK      2
`define RPS_S2_NO_CLK       1
`define RPS_S2_CNT_CHG      0

// Reset values
`define RPS_FLAGS_RST      4'h0
`define RPS_BYTE_RST       8'h00

`endif

// File: src/rps_rx_port_link_status_regs.v
// Per-port receive link status registers with port-selected readback
//
// Functional notes
// [R01] Lock change flag, bit 4, sets on lock toggle, clears on read.
// [R02] Enhanced control off: bit 3 is sequence fault, cleared on read.
// [R03] Enhanced control on: bit 3 summarises faults, cleared by detail read.
// [R04] Parity bit 2 high while count exceeds threshold until counters cleared.
// [R05] Bit 1 shows live pass indication from pass criteria logic.
// [R06] Bit 0 shows live link lock state.
// [R07] Bit 7 of status two: line length unsteady, holds until read.
// [R08] Bit 6: line length changed, clears on read.
// [R09] Bit 5: encoding fault, clears on read; needs error counting enabled.
// [R10] Bit 4: packet buffer overflow, clears on read.
// [R11] Bit 3: read-only camera-serial receive error summary.
// [R12] Bit 2 frequency settled, bit 1 link clock absent, both read-only.
// [R13] Bit 0: line count changed, clears on read.
// [R14] Integer MHz of measured frequency, read-only 8 bits.
// [R15] Status exists per port; software selects port before reading.
// [R16] Read-port select field 5:4 picks port 0 to 3.
// [R17] Fractional frequency in 1/256 MHz in the low byte register.
// [R18] Event in the clearing-read cycle stays set.
`timescale 1ns/10ps
`default_nettype none
`include "rps_defs.vh"

module rps_rx_port_link_status_regs #(
  parameter NPORT = 4
) (
  // Clock and reset
  input  wire                 clk,
  input  wire                 rst_b,
  // Register access port (from the serial management slave)
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  input  wire [7:0]           reg_addr,
  input  wire [7:0]           reg_wdata,
  output reg  [7:0]           reg_rdata,
  output reg                  reg_rvalid,
  // Per-port live status, one bit per port
  input  wire [NPORT-1:0]     link_locked,
  input  wire [NPORT-1:0]     port_pass,
  input  wire [NPORT-1:0]     parity_over_threshold,
  input  wire [NPORT-1:0]     parity_counter_clear,
  input  wire [NPORT-1:0]     enhanced_ctrl_fault_enable,
  input  wire [NPORT-1:0]     ctrl_crc_event,
  input  wire [NPORT-1:0]     ctrl_sequence_event,
  input  wire [NPORT-1:0]     ctrl_any_fault_event,
  input  wire [NPORT-1:0]     line_length_unsteady_event,
  input  wire [NPORT-1:0]     line_length_change_event,
  input  wire [NPORT-1:0]     link_encoding_event,
  input  wire [NPORT-1:0]     buffer_overflow_event,
  input  wire [NPORT-1:0]     line_count_change_event,
  input  wire [NPORT-1:0]     camera_serial_rx_error,
  input  wire [NPORT-1:0]     frequency_settled,
  input  wire [NPORT-1:0]     link_clock_absent,
  // Measured frequency per port, packed port 0 in the low byte
  input  wire [8*NPORT-1:0]   frequency_integer_mhz,
  input  wire [8*NPORT-1:0]   frequency_fraction,
  // Current port select value
  output reg  [7:0]           port_select_q
);

  // Sticky flags per port, and the previous lock level
  reg [NPORT-1:0] lock_prev_r;
  reg [NPORT-1:0] lock_chg_r;
  reg [NPORT-1:0] crc_r;
  reg [NPORT-1:0] seq_r;
  reg [NPORT-1:0] summ_r;
  reg [NPORT-1:0] parity_r;
  reg [NPORT-1:0] len_unst_r;
  reg [NPORT-1:0] len_chg_r;
  reg [NPORT-1:0] enc_r;
  reg [NPORT-1:0] buf_r;
  reg [NPORT-1:0] cnt_chg_r;

  wire [1:0] rport = port_select_q[`RPS_SEL_READ_HI:`RPS_SEL_READ_LO];

  // Clearing reads only hit the selected port
  wire rd_s1  = reg_rd && (reg_addr == `RPS_OFS_STATUS_ONE);
  wire rd_s2  = reg_rd && (reg_addr == `RPS_OFS_STATUS_TWO);
  wire rd_det = reg_rd && (reg_addr == `RPS_OFS_FAULT_DET);

  // Sticky update: set wins over clear so no event is lost
  function sticky;
    input cur;
    input ev;
    input clr;
    begin
      sticky = ev | (cur & ~clr);
    end
  endfunction

  // Port select register; write enables of bits 3:0 are kept for readback
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_select_q <= `RPS_PORT_SEL_RST;
    end else if (reg_wr && reg_addr == `RPS_OFS_PORT_SEL) begin
      // [R16] read port select
      port_select_q <= {2'b00, reg_wdata[5:0]};
    end
  end

  // Flag state per port
  integer i;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_prev_r <= {NPORT{1'b0}};
      lock_chg_r  <= {NPORT{1'b0}};
      crc_r       <= {NPORT{1'b0}};
      seq_r       <= {NPORT{1'b0}};
      summ_r      <= {NPORT{1'b0}};
      parity_r    <= {NPORT{1'b0}};
      len_unst_r  <= {NPORT{1'b0}};
      len_chg_r   <= {NPORT{1'b0}};
      enc_r       <= {NPORT{1'b0}};
      buf_r       <= {NPORT{1'b0}};
      cnt_chg_r   <= {NPORT{1'b0}};
    end else begin
      lock_prev_r <= link_locked;
      for (i = 0; i < NPORT; i = i + 1) begin
        // [R15] clears apply to selected port only
        // [R01] lock toggle detect
        // [R18] set beats clear
        lock_chg_r[i] <= sticky(lock_chg_r[i], link_locked[i] ^ lock_prev_r[i],
                                rd_s1 && rport == i[1:0]);
        crc_r[i] <= sticky(crc_r[i], ctrl_crc_event[i], rd_s1 && rport == i[1:0]);
        // [R02] sequence fault cleared on read
        seq_r[i] <= sticky(seq_r[i], ctrl_sequence_event[i], rd_s1 && rport == i[1:0]);
        // [R03] summary cleared by detail read
        summ_r[i] <= sticky(summ_r[i], ctrl_any_fault_event[i], rd_det && rport == i[1:0]);
        // [R04] held until counters cleared
        parity_r[i] <= parity_over_threshold[i] |
                       (parity_r[i] & ~parity_counter_clear[i]);
        // [R07] unsteady line length
        len_unst_r[i] <= sticky(len_unst_r[i], line_length_unsteady_event[i],
                                rd_s2 && rport == i[1:0]);
        // [R08] line length change
        len_chg_r[i] <= sticky(len_chg_r[i], line_length_change_event[i],
                               rd_s2 && rport == i[1:0]);
        // [R09] encoding fault, qualified upstream
        enc_r[i] <= sticky(enc_r[i], link_encoding_event[i], rd_s2 && rport == i[1:0]);
        // [R10] buffer overflow
        buf_r[i] <= sticky(buf_r[i], buffer_overflow_event[i], rd_s2 && rport == i[1:0]);
        // [R13] line count change
        cnt_chg_r[i] <= sticky(cnt_chg_r[i], line_count_change_event[i],
                               rd_s2 && rport == i[1:0]);
      end
    end
  end

  // Readback mux of the selected port
  reg [7:0] rdata_nxt;
  always @* begin
    rdata_nxt = `RPS_BYTE_RST;
    case (reg_addr)
      `RPS_OFS_PORT_SEL: rdata_nxt = port_select_q;
      `RPS_OFS_STATUS_ONE: begin
        rdata_nxt[`RPS_S1_PORT_HI:`RPS_S1_PORT_LO] = rport;
        rdata_nxt[`RPS_S1_CRC]      = crc_r[rport];
        // [R01] lock change flag
        rdata_nxt[`RPS_S1_LOCK_CHG] = lock_chg_r[rport];
        // [R02] [R03] meaning by enhanced control
        rdata_nxt[`RPS_S1_CTRL]     = enhanced_ctrl_fault_enable[rport] ?
                                      summ_r[rport] : seq_r[rport];
        // [R04] parity flag, live level or held copy
        // Live term covers the cycle before the held copy catches up
        rdata_nxt[`RPS_S1_PARITY]   = parity_r[rport] | parity_over_threshold[rport];
        // [R05] live pass
        rdata_nxt[`RPS_S1_PASS]     = port_pass[rport];
        // [R06] live lock
        rdata_nxt[`RPS_S1_LOCKED]   = link_locked[rport];
      end
      `RPS_OFS_STATUS_TWO: begin
        rdata_nxt[`RPS_S2_LEN_UNSTEADY] = len_unst_r[rport];
        rdata_nxt[`RPS_S2_LEN_CHG]      = len_chg_r[rport];
        rdata_nxt[`RPS_S2_ENCODE]       = enc_r[rport];
        rdata_nxt[`RPS_S2_BUFFER]       = buf_r[rport];
        // [R11] camera error summary
        rdata_nxt[`RPS_S2_CAMERA]       = camera_serial_rx_error[rport];
        // [R12] settled and clock absent
        rdata_nxt[`RPS_S2_FREQ_OK]      = frequency_settled[rport];
        rdata_nxt[`RPS_S2_NO_CLK]       = link_clock_absent[rport];
        rdata_nxt[`RPS_S2_CNT_CHG]      = cnt_chg_r[rport];
      end
      // [R14] integer MHz
      `RPS_OFS_FREQ_INT:  rdata_nxt = frequency_integer_mhz[8*rport +: 8];
      // [R17] fraction in 1/256 MHz
      `RPS_OFS_FREQ_FRAC: rdata_nxt = frequency_fraction[8*rport +: 8];
      default: rdata_nxt = `RPS_BYTE_RST;
    endcase
  end

  // Registered read answer, one cycle after the read strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= `RPS_BYTE_RST;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

endmodule
`default_nettype wire

// File: verif/rps_far_end.sv
// Far-end serializer model: per-port status events, levels and frequency
`timescale 1ns/10ps
`default_nettype none
module rps_far_end (
  // Clock in, link status out
  input  wire logic        clk,
  output var  logic [35:0] ev,
  output var  logic [27:0] lv,
  output wire logic [31:0] fi,
  output wire logic [31:0] ff
);
  // Distinct bytes per port so a wrong port select shows
  assign fi = 32'h84838281;
  assign ff = 32'h0c0b0a09;
  initial lv = 28'h0;
  initial ev = 36'h0;
  always @(posedge clk) ev <= 36'h0;
  task automatic hit(input int k, input int p);
    ev[4*k+p] = 1'b1;
  endtask
  task automatic lvl(input int k, input int p, input logic v);
    lv[4*k+p] = v;
  endtask
endmodule
`default_nettype wire

// File: verif/rps_status_assertions.sv
// Checker for status readback timing and live bits
`timescale 1ns/10ps
`default_nettype none
module rps_status_checker #(
  parameter NPORT = 4
) (
  // Watched design ports
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_rdata,
  input wire logic               reg_rvalid,
  input wire logic [7:0]         port_select_q,
  input wire logic [NPORT-1:0]   link_locked,
  input wire logic [NPORT-1:0]   parity_over_threshold,
  input wire logic [8*NPORT-1:0] frequency_integer_mhz
);
  // Selected port and status one reads
  wire [1:0] sel = port_select_q[5:4];
  wire       rd1 = reg_rd && reg_addr == 8'h4d;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  rvalid_follow_a: assert property (reg_rd |=> reg_rvalid) else $error("rvalid missing");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
  lock_live_a: assert property (rd1 |=> reg_rdata[0] == $past(link_locked[sel]))
    else $error("lock bit wrong");
  parity_set_a: assert property (rd1 && parity_over_threshold[sel] |=> reg_rdata[2])
    else $error("parity bit low");
  port_field_a: assert property (rd1 |=> reg_rdata[7:6] == $past(sel))
    else $error("port field wrong");
  freq_int_a: assert property (reg_rd && reg_addr == 8'h4f
    |=> reg_rdata == $past(frequency_integer_mhz[8*sel +: 8])) else $error("freq wrong");
  unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h60 |=> reg_rdata == 8'h00)
    else $error("unmapped not zero");
  cover property (rd1 && link_locked[sel]);
  cover property (reg_rd && reg_addr == 8'h4f && sel == 2'h3);
  cover property (reg_rd && reg_addr == 8'h60);
endmodule
bind rps_rx_port_link_status_regs rps_status_checker #(.NPORT(NPORT)) chk_i (.clk(clk),
  .rst_b(rst_b), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .port_select_q(port_select_q), .link_locked(link_locked),
  .parity_over_threshold(parity_over_threshold), .frequency_integer_mhz(frequency_integer_mhz));
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the per-port receive status registers
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       clk, rst_b, wr, rd;
  logic [7:0] ad, wd;
  wire  [7:0] rdat, psel;
  wire [35:0] ev;
  wire [27:0] lv;
  wire [31:0] fi, ff;
  int         miscompares, checks_done, cyc;
  rps_far_end far (.clk(clk), .ev(ev), .lv(lv), .fi(fi), .ff(ff));
  rps_rx_port_link_status_regs #(.NPORT(4)) dut (.clk(clk), .rst_b(rst_b), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(),
    .link_locked(lv[3:0]), .port_pass(lv[7:4]), .parity_over_threshold(lv[11:8]),
    .enhanced_ctrl_fault_enable(lv[15:12]), .camera_serial_rx_error(lv[19:16]),
    .frequency_settled(lv[23:20]), .link_clock_absent(lv[27:24]), .ctrl_crc_event(ev[3:0]),
    .ctrl_sequence_event(ev[7:4]), .ctrl_any_fault_event(ev[11:8]),
    .line_length_unsteady_event(ev[15:12]), .line_length_change_event(ev[19:16]),
    .link_encoding_event(ev[23:20]), .buffer_overflow_event(ev[27:24]),
    .line_count_change_event(ev[31:28]), .parity_counter_clear(ev[35:32]),
    .frequency_integer_mhz(fi), .frequency_fraction(ff), .port_select_q(psel));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, exp, got);
    end
  endtask
  // One access from a falling edge, then an idle cycle so strobes never re-assert at once
  task automatic rg(input logic w, input logic [7:0] a, input logic [7:0] d);
    {wr, rd, ad, wd} = {w, !w, a, d};
    @(negedge clk);
    {wr, rd} = 2'b00;
    @(negedge clk);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
    rg(1'b0, a, 8'h00);
    chk(n, rdat, e);
  endtask
  task automatic t_lock();
    far.lvl(0, 0, 1'b1);
    repeat (2) @(negedge clk);
    rdc("lock set", 8'h4d, 8'h11);
    rdc("lock kept", 8'h4d, 8'h01);
    far.lvl(0, 0, 1'b0);
    repeat (2) @(negedge clk);
    rdc("lock lost", 8'h4d, 8'h10);
  endtask
  task automatic t_ctrl();
    far.hit(1, 0);
    @(negedge clk);
    rdc("seq", 8'h4d, 8'h08);
    far.hit(1, 0);
    rg(1'b0, 8'h4d, 8'h00);
    rdc("seq kept", 8'h4d, 8'h08);
    rdc("seq clr", 8'h4d, 8'h00);
    far.lvl(3, 0, 1'b1);
    far.hit(2, 0);
    @(negedge clk);
    rdc("sum", 8'h4d, 8'h08);
    rdc("sum kept", 8'h4d, 8'h08);
    rdc("detail", 8'h5a, 8'h00);
    rdc("sum clr", 8'h4d, 8'h00);
    far.lvl(3, 0, 1'b0);
  endtask
  task automatic t_par();
    far.lvl(2, 0, 1'b1);
    @(negedge clk);
    rdc("par", 8'h4d, 8'h04);
    far.lvl(2, 0, 1'b0);
    rdc("par kept", 8'h4d, 8'h04);
    far.hit(8, 0);
    @(negedge clk);
    rdc("par clr", 8'h4d, 8'h00);
  endtask
  task automatic t_two();
    rg(1'b1, 8'h4c, 8'h20);
    chk("sel", psel, 8'h20);
    for (int k = 1; k < 7; k++) far.lvl(k, 2, k > 3 || k == 1);
    for (int k = 3; k < 8; k++) far.hit(k, 2);
    @(negedge clk);
    rg(1'b1, 8'h4e, 8'h00);
    rdc("two", 8'h4e, 8'hff);
    rdc("two clr", 8'h4e, 8'h0e);
    rdc("one p2", 8'h4d, 8'h82);
    for (int k = 1; k < 7; k++) far.lvl(k, 2, 1'b0);
    rg(1'b1, 8'h4c, 8'h00);
    rdc("two p0", 8'h4e, 8'h00);
  endtask
  task automatic t_freq();
    for (int p = 0; p < 4; p++) begin
      rg(1'b1, 8'h4c, 8'(p << 4));
      rdc("int", 8'h4f, 8'h81 + 8'(p));
      rdc("frac", 8'h50, 8'h09 + 8'(p));
    end
    rg(1'b1, 8'h4c, 8'hff);
    chk("sel top", psel, 8'h3f);
    rdc("unmapped", 8'h60, 8'h00);
    rg(1'b1, 8'h4c, 8'h00);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Run is about 90 cycles; a hang stops well short of forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    {rst_b, wr, rd, ad, wd} = 19'h0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    rdc("one rst", 8'h4d, 8'h00);
    t_lock();
    t_ctrl();
    t_par();
    t_two();
    t_freq();
    report_and_stop();
  end
endmodule
`default_nettype wire
